//--- nvmp_defines.svh
// constants for the serial non-volatile memory programming port
`ifndef NVMP_DEFINES_SVH
`define NVMP_DEFINES_SVH

// instruction bytes
`define NVMP_OP_ENABLE1   8'hAC
`define NVMP_OP_ENABLE2   8'h53
`define NVMP_OP_LD_PAGE   8'h40
`define NVMP_OP_WR_PAGE   8'h4C
`define NVMP_OP_RD_FLASH  8'h20
`define NVMP_OP_RD_EE     8'hA0
`define NVMP_OP_WR_EE     8'hC0
`define NVMP_OP_HMASK     8'hF7
`define NVMP_CE_SEL       3'h4

// memory shape and erased value
`define NVMP_ERASED       8'hFF
`define NVMP_ERASED_WORD  16'hFFFF
`define NVMP_FLASH_WORDS  16384
`define NVMP_EE_BYTES     1024
`define NVMP_PAGE_WORDS   64

// framing: bit counter values at the last bit of byte 2, byte 3 and byte 4
`define NVMP_CNT_BYTE2    6'h0F
`define NVMP_CNT_HDR      6'h17
`define NVMP_CNT_LAST     6'h1F

// self-timed write lengths in timing-clock cycles
`define NVMP_FLASH_WR_RC  8192
`define NVMP_EE_WR_RC     2048

`endif

//--- nvmp_pkg.sv
// types shared by the programming port modules
package nvmp_pkg;
  typedef enum logic {
    WK_FLASH = 1'b0,
    WK_EE    = 1'b1
  } nvmp_wkind_e;

  typedef enum logic {
    T_IDLE = 1'b0,
    T_RUN  = 1'b1
  } nvmp_tstate_e;

  typedef logic [15:0] nvmp_word_t;
  typedef logic [7:0]  nvmp_byte_t;
  typedef logic [13:0] nvmp_faddr_t;
  typedef logic [9:0]  nvmp_eaddr_t;
endpackage

//--- nvmp_prog_model.sv
// in-system programmer model driving the serial programming link
`timescale 1ns/1ps
module nvmp_prog_model #(
  parameter real HALF = 11.3
) (
  // device reset pin
  output logic      dev_reset_n,
  // serial link
  output logic      sck,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  // ==========================================================================
  // power-up state
  initial begin
    dev_reset_n = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // ==========================================================================
  // link primitives
  task automatic pulse();
    sck = 1'b1;
    #HALF;
    sck = 1'b0;
    #HALF;
  endtask

  // one four-byte frame, msb first; sck rests low between frames
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    for (int k = 31; k >= 0; k--) begin
      mosi = tx[k];
      #HALF;
      rx[k] = miso;
      sck = 1'b1;
      #HALF;
      sck = 1'b0;
    end
    // no pull on the line, so a released mosi must not look stable
    mosi = ~mosi;
    #HALF;
  endtask

  // reset pulse high then low; power-up wait cut to a few cycles
  task automatic start_session();
    dev_reset_n = 1'b1;
    #20;
    dev_reset_n = 1'b0;
    #40;
    repeat (3) pulse();
  endtask

  task automatic end_session();
    dev_reset_n = 1'b1;
    #40;
  endtask

  // enable with sck-pulse retry
  task automatic enable(output logic ok);
    logic [31:0] rx;
    ok = 1'b0;
    for (int n = 0; n < 32 && ok !== 1'b1; n++) begin
      frame(32'hAC53_0000, rx);
      ok = (rx[15:8] === 8'h53);
      if (ok !== 1'b1) begin
        pulse();
      end
    end
  endtask
endmodule

//--- nvmp_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module nvmp_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst,
  // level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

//--- nvmp_tmr_if.sv
// link-to-timer handshake between the serial side and the write timer
`timescale 1ns/1ps
interface nvmp_tmr_if;
  import nvmp_pkg::*;
  logic        start_tgl;
  nvmp_wkind_e kind;
  logic        done_tgl;

  modport link  (output start_tgl, output kind, input done_tgl);
  modport timer (input start_tgl, input kind, output done_tgl);
endinterface

//--- nvmp_top.sv
// serial programming port for program flash and data eeprom
// What this block does
// - programming accepted over sck/mosi/miso only while the device reset pin is low
// - program and erase ignored until a programming enable instruction is executed
// - each eeprom byte write erases its target itself, no chip erase needed
// - chip erase sets every flash and eeprom location to ff
// - flash word addresses 0..3fff, eeprom byte addresses 0..3ff, separate spaces
// - incoming bits are captured on the rising sck edge
// - outgoing bits are driven on the falling sck edge
// - in sync, the second enable byte 53 echoes during the third byte
// - flash loads a page buffer by 6 lsb, commits by 8 msb page address
// - eeprom written one byte per instruction, programmer waits or polls
// - read instructions return the addressed flash or eeprom content after enable, 00 before it
// - reads inside a page being written give ff until the write ends
// - read of an eeprom byte being written gives ff until it ends
// - flash page write lasts 8k timing cycles, eeprom byte write 2k
// - every instruction is four bytes; enable is ac 53 then two don't-care bytes
`timescale 1ns/1ps
`include "nvmp_defines.svh"
module nvmp_top import nvmp_pkg::*; #(
  parameter int unsigned FLASH_WR_CYC = `NVMP_FLASH_WR_RC
) (
  // core clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // device reset pin, programming while low
  input  wire logic dev_reset_n,
  // serial link
  input  wire logic sck,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // status
  output logic      wr_busy
);
  // ==========================================================
  // core clock side
  logic pin_hi;
  logic pin_hi_prev_q;
  logic gen_q;
  logic tmr_busy;

  nvmp_tmr_if tmr_if ();

  nvmp_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (dev_reset_n),
    .q   (pin_hi)
  );

  // a reset pulse is seen here even while sck stands still
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_hi_prev_q <= 1'b1;
      gen_q         <= 1'b0;
    end else begin
      pin_hi_prev_q <= pin_hi;
      if (pin_hi_prev_q && !pin_hi) begin
        gen_q <= ~gen_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      miso_oe <= 1'b0;
      wr_busy <= 1'b0;
    end else begin
      miso_oe <= ~pin_hi;
      wr_busy <= tmr_busy;
    end
  end

  nvmp_wtimer #(.FLASH_CYC(FLASH_WR_CYC)) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tmr     (tmr_if.timer),
    .busy    (tmr_busy)
  );

  // ==========================================================
  // link side, clocked by sck
  logic        lrst;
  logic        link_act;
  logic        gen_s;
  logic        done_s;
  logic [5:0]  cnt_q;
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic        prog_en_q;
  logic        gen_seen_q;
  nvmp_byte_t  ld_q;
  logic        start_tgl_q;
  nvmp_wkind_e kind_q;
  logic [7:0]  busy_page_q;
  nvmp_eaddr_t busy_eaddr_q;
  logic        busy_l;
  logic        gen_ok;
  logic        frame_go;
  nvmp_byte_t  rd_data;

  nvmp_word_t  flash_mem [`NVMP_FLASH_WORDS];
  nvmp_byte_t  ee_mem    [`NVMP_EE_BYTES];
  nvmp_word_t  page_buf  [`NVMP_PAGE_WORDS];

  nvmp_sync #(.W(1), .RST_VAL(1'b1)) u_lrst_sync (
    .clk (sck),
    .rst (1'b0),
    .d   (sys_rst),
    .q   (lrst)
  );

  nvmp_sync #(.W(3), .RST_VAL(3'h0)) u_link_sync (
    .clk (sck),
    .rst (lrst),
    .d   ({~dev_reset_n, gen_q, tmr_if.done_tgl}),
    .q   ({link_act, gen_s, done_s})
  );

  assign rx_d     = {rx_q[30:0], mosi};
  assign gen_ok   = (gen_s == gen_seen_q);
  assign frame_go = link_act && gen_ok && (cnt_q == `NVMP_CNT_LAST);
  assign busy_l   = start_tgl_q ^ done_s;

  // frame fields at the last bit
  nvmp_byte_t b1;
  nvmp_byte_t b2;
  nvmp_byte_t b3;
  nvmp_byte_t b4;
  logic       is_pe;
  logic       is_ce;
  logic       is_lp;
  logic       is_wp;
  logic       is_we;
  assign b1    = rx_d[31:24];
  assign b2    = rx_d[23:16];
  assign b3    = rx_d[15:8];
  assign b4    = rx_d[7:0];
  assign is_pe = (b1 == `NVMP_OP_ENABLE1) && (b2 == `NVMP_OP_ENABLE2);
  assign is_ce = (b1 == `NVMP_OP_ENABLE1) && (b2[7:5] == `NVMP_CE_SEL);
  assign is_lp = ((b1 & `NVMP_OP_HMASK) == `NVMP_OP_LD_PAGE);
  assign is_wp = (b1 == `NVMP_OP_WR_PAGE);
  assign is_we = (b1 == `NVMP_OP_WR_EE);

  // rising edge: capture and framing
  always_ff @(posedge sck) begin
    if (lrst) begin
      rx_q <= 32'h0000_0000;
    end else begin
      rx_q <= rx_d;
    end
  end

  // a new session restarts framing; the edge that notices it is dropped
  always_ff @(posedge sck) begin
    if (lrst) begin
      cnt_q      <= 6'h00;
      gen_seen_q <= 1'b0;
    end else if (!gen_ok) begin
      cnt_q      <= 6'h00;
      gen_seen_q <= gen_s;
    end else if (!link_act) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= (cnt_q == `NVMP_CNT_LAST) ? 6'h00 : cnt_q + 6'h01;
    end
  end

  always_ff @(posedge sck) begin
    if (lrst || !gen_ok || !link_act) begin
      prog_en_q <= 1'b0;
    end else if (frame_go && is_pe) begin
      prog_en_q <= 1'b1;
    end
  end

  // read lookup on the three header bytes, result shifted out in byte 4
  always_comb begin
    nvmp_faddr_t fa;
    nvmp_eaddr_t ea;
    nvmp_word_t  w;
    fa      = {rx_d[13:8], rx_d[7:0]};
    ea      = {rx_d[9:8], rx_d[7:0]};
    w       = flash_mem[fa];
    rd_data = 8'h00;
    if (prog_en_q && (rx_d[23:16] & `NVMP_OP_HMASK) == `NVMP_OP_RD_FLASH) begin
      rd_data = rx_d[19] ? w[15:8] : w[7:0];
      if (busy_l && kind_q == WK_FLASH && fa[13:6] == busy_page_q) begin
        rd_data = `NVMP_ERASED;
      end
    end else if (prog_en_q && rx_d[23:16] == `NVMP_OP_RD_EE) begin
      rd_data = ee_mem[ea];
      if (busy_l && kind_q == WK_EE && ea == busy_eaddr_q) begin
        rd_data = `NVMP_ERASED;
      end
    end
  end

  // byte boundary: echo the last byte, or the read result for byte 4
  always_ff @(posedge sck) begin
    if (lrst) begin
      ld_q <= 8'h00;
    end else if (link_act && gen_ok && cnt_q[2:0] == 3'h7) begin
      if (cnt_q == `NVMP_CNT_HDR) begin
        ld_q <= rd_data;
      end else begin
        ld_q <= rx_d[7:0];
      end
    end
  end

  // falling edge: drive the next outgoing bit
  always_ff @(negedge sck) begin
    if (lrst) begin
      miso <= 1'b0;
    end else begin
      miso <= ld_q[3'h7 - cnt_q[2:0]];
    end
  end

  // self-timed write start; survives session resets so busy stays honest
  always_ff @(posedge sck) begin
    if (lrst) begin
      start_tgl_q  <= 1'b0;
      kind_q       <= WK_FLASH;
      busy_page_q  <= 8'h00;
      busy_eaddr_q <= 10'h000;
    end else if (frame_go && prog_en_q && is_wp) begin
      start_tgl_q <= ~start_tgl_q;
      kind_q      <= WK_FLASH;
      busy_page_q <= {b2[5:0], b3[7:6]};
    end else if (frame_go && prog_en_q && is_we) begin
      start_tgl_q  <= ~start_tgl_q;
      kind_q       <= WK_EE;
      busy_eaddr_q <= {b2[1:0], b3};
    end
  end

  assign tmr_if.start_tgl = start_tgl_q;
  assign tmr_if.kind      = kind_q;

  // arrays update at once; reads are masked until the timer reports done
  always_ff @(posedge sck) begin
    if (frame_go && prog_en_q) begin
      if (is_ce) begin
        for (int i = 0; i < `NVMP_FLASH_WORDS; i++) begin
          flash_mem[i] <= `NVMP_ERASED_WORD;
        end
        for (int i = 0; i < `NVMP_EE_BYTES; i++) begin
          ee_mem[i] <= `NVMP_ERASED;
        end
      end else if (is_lp) begin
        if (b1[3]) begin
          page_buf[b3[5:0]][15:8] <= b4;
        end else begin
          page_buf[b3[5:0]][7:0] <= b4;
        end
      end else if (is_wp) begin
        for (int i = 0; i < `NVMP_PAGE_WORDS; i++) begin
          flash_mem[{b2[5:0], b3[7:6], 6'(i)}] <= page_buf[i];
        end
      end else if (is_we) begin
        ee_mem[{b2[1:0], b3}] <= b4;
      end
    end
  end

  // ==========================================================
  // checks
  a_rx_capture: assert property (@(posedge sck) disable iff (lrst)
    1'b1 |=> rx_q[0] == $past(mosi))
    else $error("mosi not captured on rising sck");

  a_enable_echo: assert property (@(posedge sck) disable iff (lrst)
    (link_act && gen_ok && cnt_q == `NVMP_CNT_BYTE2 && rx_d[15:0] == 16'hAC53)
      |=> ld_q == `NVMP_OP_ENABLE2)
    else $error("enable echo not loaded");

  a_miso_edge: assert property (@(posedge sck) disable iff (lrst)
    (cnt_q[2:0] == 3'h0 && $past(cnt_q[2:0]) == 3'h7 && !$past(lrst))
      |-> miso == ld_q[7])
    else $error("first bit of byte not driven on falling sck");

  a_enable_gate: assert property (@(posedge sck) disable iff (lrst)
    (frame_go && !prog_en_q && !is_pe) |=> start_tgl_q == $past(start_tgl_q)
      && prog_en_q == 1'b0)
    else $error("instruction acted on before enable");

  a_erase_all: assert property (@(posedge sck) disable iff (lrst)
    (frame_go && prog_en_q && is_ce)
      |=> flash_mem[14'h3FFF] == `NVMP_ERASED_WORD && ee_mem[10'h3FF] == `NVMP_ERASED)
    else $error("chip erase left a location set");

  a_page_commit: assert property (@(posedge sck) disable iff (lrst)
    (frame_go && prog_en_q && is_wp)
      |=> flash_mem[{busy_page_q, 6'h00}] == $past(page_buf[0]) && busy_l)
    else $error("page not committed or timer not started");

  a_flash_mask: assert property (@(posedge sck) disable iff (lrst)
    (prog_en_q && busy_l && kind_q == WK_FLASH
      && (rx_d[23:16] & `NVMP_OP_HMASK) == `NVMP_OP_RD_FLASH
      && rx_d[13:6] == busy_page_q) |-> rd_data == `NVMP_ERASED)
    else $error("busy flash page read not masked");

  a_ee_mask: assert property (@(posedge sck) disable iff (lrst)
    (prog_en_q && busy_l && kind_q == WK_EE && rx_d[23:16] == `NVMP_OP_RD_EE
      && rx_d[9:0] == busy_eaddr_q) |-> rd_data == `NVMP_ERASED)
    else $error("busy eeprom byte read not masked");

  a_ee_write: assert property (@(posedge sck) disable iff (lrst)
    (frame_go && prog_en_q && is_we)
      |=> ee_mem[busy_eaddr_q] == $past(b4) && kind_q == WK_EE && busy_l)
    else $error("eeprom byte not written");

  c_enable: cover property (@(posedge sck) disable iff (lrst) frame_go && is_pe);
  c_erase: cover property (@(posedge sck) disable iff (lrst) frame_go && prog_en_q && is_ce);
  c_page: cover property (@(posedge sck) disable iff (lrst) frame_go && prog_en_q && is_wp);
  c_poll: cover property (@(posedge sck) disable iff (lrst)
    busy_l && cnt_q == `NVMP_CNT_HDR && rd_data == `NVMP_ERASED);
endmodule

//--- nvmp_top_tb.sv
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module nvmp_top_tb;
  import nvmp_pkg::*;
  localparam int unsigned FCYC = 400;
  logic clk;
  logic sys_rst;
  logic dev_reset_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic wr_busy;
  int   failures;
  int   n_checks;

  nvmp_top #(.FLASH_WR_CYC(FCYC)) i_nvmp_top (
    .clk(clk), .sys_rst(sys_rst), .dev_reset_n(dev_reset_n), .sck(sck),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wr_busy(wr_busy)
  );
  nvmp_prog_model i_nvmp_prog_model (
    .dev_reset_n(dev_reset_n), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // compare and report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_byte({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // instruction helpers
  task automatic rd_ee(input logic [9:0] a, output logic [7:0] d);
    logic [31:0] rx;
    i_nvmp_prog_model.frame({8'hA0, 6'h00, a, 8'h00}, rx);
    d = rx[7:0];
  endtask

  task automatic rd_fl(input logic [13:0] a, input logic hi, output logic [7:0] d);
    logic [31:0] rx;
    i_nvmp_prog_model.frame({4'h2, hi, 3'h0, 2'b00, a, 8'h00}, rx);
    d = rx[7:0];
  endtask

  task automatic send(input logic [31:0] tx);
    logic [31:0] rx;
    i_nvmp_prog_model.frame(tx, rx);
  endtask

  // counts clk cycles of one busy period
  task automatic busy_len(input int exp_n);
    int n;
    n = 0;
    for (int w = 0; w < 400 && wr_busy !== 1'b1; w++) begin
      @(posedge clk);
      #1;
    end
    while (wr_busy === 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_cnt(n, exp_n, "busy length");
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_refuse();
    logic [7:0] d;
    chk_bit(miso_oe, 1'b1, "oe in session");
    rd_ee(10'h000, d);
    chk_byte(d, 8'h00, "locked read");
    send({8'hC0, 6'h00, 10'h000, 8'h12});
    repeat (10) @(posedge clk);
    #1;
    chk_bit(wr_busy, 1'b0, "locked write");
  endtask

  task automatic t_enable();
    logic [31:0] rx;
    i_nvmp_prog_model.frame(32'hAC53_0000, rx);
    chk_byte(rx[15:8], 8'h53, "enable echo");
  endtask

  task automatic t_erase();
    logic [7:0] d;
    logic       ok;
    send(32'hAC80_0000);
    rd_fl(14'h3FFF, 1'b1, d);
    chk_byte(d, 8'hFF, "erased flash top");
    rd_fl(14'h0000, 1'b0, d);
    chk_byte(d, 8'hFF, "erased flash bottom");
    rd_ee(10'h3FF, d);
    chk_byte(d, 8'hFF, "erased eeprom top");
    repeat (2 * FCYC) @(posedge clk);
    #1;
    i_nvmp_prog_model.start_session();
    i_nvmp_prog_model.enable(ok);
    chk_bit(ok, 1'b1, "enable after erase");
  endtask

  // write, poll during the write, read back once done
  task automatic ee_step(input logic [9:0] a, input logic [7:0] v);
    logic [7:0] d;
    fork
      busy_len(2048);
      begin
        send({8'hC0, 6'h00, a, v});
        rd_ee(a, d);
        chk_byte(d, 8'hFF, "eeprom in write");
      end
    join
    rd_ee(a, d);
    chk_byte(d, v, "eeprom readback");
  endtask

  task automatic t_flash();
    logic [7:0] d;
    logic [7:0] exp [4];
    exp = '{8'h12, 8'h34, 8'h56, 8'h78};
    for (int i = 0; i < 4; i++) begin
      send({4'h4, i[0], 3'h0, 8'h00, 2'b00, {6{i[1]}}, exp[i]});
    end
    fork
      busy_len(FCYC);
      begin
        send({8'h4C, 2'b00, 6'h3F, 2'b11, 6'h00, 8'h00});
        rd_fl(14'h3FFF, 1'b1, d);
        chk_byte(d, 8'hFF, "page in write");
      end
    join
    for (int i = 0; i < 4; i++) begin
      rd_fl({8'hFF, {6{i[1]}}}, i[0], d);
      chk_byte(d, exp[i], "flash readback");
    end
    rd_fl(14'h3FBF, 1'b1, d);
    chk_byte(d, 8'hFF, "neighbour page");
  endtask

  task automatic t_end();
    logic [7:0] d;
    logic       ok;
    i_nvmp_prog_model.end_session();
    chk_bit(miso_oe, 1'b0, "oe after session");
    send({8'hC0, 6'h00, 10'h001, 8'h33});
    repeat (10) @(posedge clk);
    #1;
    chk_bit(wr_busy, 1'b0, "write outside session");
    i_nvmp_prog_model.start_session();
    i_nvmp_prog_model.enable(ok);
    chk_bit(ok, 1'b1, "second session");
    rd_ee(10'h001, d);
    chk_byte(d, 8'hFF, "ignored write");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    sys_rst = 1'b1;
    failures = 0;
    n_checks = 0;
    // the sck side resets only on sck edges
    repeat (3) @(posedge clk);
    #1;
    repeat (4) i_nvmp_prog_model.pulse();
    @(posedge clk);
    #1;
    sys_rst = 1'b0;
    // pin low since power-up: its first fall opens the session,
    // two edges release the sck side, three more align the framing
    repeat (4) @(posedge clk);
    #1;
    repeat (5) i_nvmp_prog_model.pulse();
    t_refuse();
    t_enable();
    t_erase();
    ee_step(10'h3FF, 8'h5A);
    ee_step(10'h3FF, 8'hA5);
    t_flash();
    t_end();
    final_report();
  end

  initial begin
    #300us;
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    final_report();
  end
endmodule

//--- nvmp_wtimer.sv
// self-timed write duration counter on the core clock
`timescale 1ns/1ps
`include "nvmp_defines.svh"
module nvmp_wtimer import nvmp_pkg::*; #(
  parameter int unsigned FLASH_CYC = `NVMP_FLASH_WR_RC
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // handshake with the serial side
  nvmp_tmr_if.timer  tmr,
  // write in progress
  output logic       busy
);
  localparam int unsigned EE_CYC = `NVMP_EE_WR_RC;

  logic         start_s;
  logic         start_seen_q;
  logic         done_q;
  nvmp_tstate_e state_q;
  logic [13:0]  cnt_q;
  nvmp_wkind_e  kind_q;
  logic [15:0]  len_q;

  nvmp_sync #(.W(1), .RST_VAL(1'b0)) u_start_sync (
    .clk (clk),
    .rst (sys_rst),
    .d   (tmr.start_tgl),
    .q   (start_s)
  );

  // kind is held steady by the link side while its toggle crosses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_seen_q <= 1'b0;
      state_q      <= T_IDLE;
      cnt_q        <= 14'h0000;
      kind_q       <= WK_FLASH;
      done_q       <= 1'b0;
    end else if (start_s != start_seen_q) begin
      start_seen_q <= start_s;
      state_q      <= T_RUN;
      kind_q       <= tmr.kind;
      cnt_q        <= (tmr.kind == WK_FLASH) ? 14'(FLASH_CYC - 1) : 14'(EE_CYC - 1);
    end else begin
      unique case (state_q)
        T_IDLE: begin
          cnt_q <= cnt_q;
        end
        T_RUN: begin
          if (cnt_q == 14'h0000) begin
            state_q <= T_IDLE;
            done_q  <= start_seen_q;
          end else begin
            cnt_q <= cnt_q - 14'h0001;
          end
        end
      endcase
    end
  end

  assign tmr.done_tgl = done_q;
  assign busy         = (state_q == T_RUN);

  // ==========================================================
  // checks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      len_q <= 16'h0000;
    end else begin
      len_q <= busy ? 16'(len_q + 16'h0001) : 16'h0000;
    end
  end

  a_write_length: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(busy) |-> len_q == ((kind_q == WK_FLASH) ? 16'(FLASH_CYC) : 16'(EE_CYC)))
    else $error("self-timed write length wrong");

  c_ee_write_done: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(busy) && kind_q == WK_EE);
endmodule
